/* File: core/lcd_panel_host_port_keyscan.sv */
// host port, command executor, display memories, key scan and extension drive
// assumes pins arrive asynchronously to clk; sclk is far slower than clk
`timescale 1ns/1ps
`include "lcd_host_map.svh"

// ****************************************
// command buffer
// ****************************************
module op_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = `OP_FIFO_DEPTH
) (
   input wire logic clk, // system clock
   input wire logic rstn, // async reset, low
   input wire logic in_valid, // writer offers word
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word in
   output logic out_valid, // word available
   input wire logic out_ready, // reader takes word
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("op_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // honest flags straight from the count
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   // pointer and count update
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
   // storage carries no reset
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr] <= in_data;
   end
endmodule

// ****************************************
// panel host port top
// ****************************************
module lcd_panel_host_port_keyscan #(
   parameter int STROBE_CYCLES = `KEY_STROBE_US * 1000 / `CLK_PERIOD_NS,
   parameter int FIFO_DEPTH = `OP_FIFO_DEPTH
) (
   input wire logic clk, // 100 MHz system clock
   input wire logic rstn, // async reset, low
   input wire logic cs_n, // chip select, low selects
   input wire logic sclk, // serial clock from host
   input wire logic serial_in, // serial data from host
   output logic serial_out, // serial data to host
   output logic irq_n, // key event interrupt, low
   input wire logic line_count_select, // high selects two lines
   output logic two_line_mode, // 1/17 duty when high
   output logic shared_drive_is_common, // shared outputs act as commons
   output logic display_on, // display enabled
   output logic ext_latch_pulse, // extension latch pulse
   output logic ext_shift_clock, // extension shift clock
   output logic ext_data, // extension dot data
   output logic ext_polarity, // extension drive polarity
   output logic [`KEY_ROWS-1:0] key_strobe_n, // key strobes, low
   input wire logic [`KEY_COLS-1:0] key_input_n // key returns, low
);
   localparam int EXEC_CYCLES = (`EXEC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int EXT_HALF_RAW = `EXT_HALF_NS / `CLK_PERIOD_NS;
   localparam int EXT_HALF = (EXT_HALF_RAW < 1) ? 1 : EXT_HALF_RAW;
   localparam int NPIN = 4 + `KEY_COLS;
   localparam logic [NPIN-1:0] PIN_IDLE = {{`KEY_COLS{1'b1}}, 3'h0, 1'b1}; // no edge after reset
   if (STROBE_CYCLES < 2 || STROBE_CYCLES >= (1 << 24)) begin
      $error("strobe interval out of counter range");
   end

   // ****************************************
   // pin synchronisers
   // ****************************************
   wire [NPIN-1:0] pin_raw = {key_input_n, line_count_select, serial_in, sclk, cs_n};
   logic [NPIN-1:0] pin_f;
   genvar gi;
   // three stages; the filtered value moves once stages two and three agree
   for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1, s2, s3;
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            {s1, s2, s3} <= {3{PIN_IDLE[gi]}};
            pin_f[gi] <= PIN_IDLE[gi];
         end else begin
            s1 <= pin_raw[gi];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) pin_f[gi] <= s3;
         end
      end
   end
   wire cs_f = pin_f[0];
   wire sclk_f = pin_f[1];
   wire sin_f = pin_f[2];
   wire line_f = pin_f[3];
   wire [`KEY_COLS-1:0] keys_pressed = ~pin_f[NPIN-1:4];

   // ****************************************
   // serial engine
   // ****************************************
   lcd_host_pkg::serial_phase_t sph;
   logic sclk_d;
   logic [2:0] bit_cnt;
   logic [7:0] rx;
   logic [7:0] tx;
   logic reg_select;
   logic [7:0] data_transfer_register;
   logic busy_flag;
   logic [2:0] scan_sel;
   logic [`KEY_COLS-1:0] scan [0:`KEY_ROWS-1];
   wire selected = !cs_f;
   wire sclk_rise = selected && sclk_f && !sclk_d;
   wire sclk_fall = selected && !sclk_f && sclk_d;
   wire byte_done = sclk_rise && (bit_cnt == 3'h7);
   wire [7:0] rx_byte = {rx[6:0], sin_f};
   wire start_ok = (rx_byte[`START_SYNC_HI:`START_SYNC_LO] == `START_SYNC);
   wire start_rw = rx_byte[`START_RW_BIT];
   wire start_sel = rx_byte[`START_SEL_BIT];
   // status word carries busy on top, one key row below; instruction reg never read
   wire [7:0] status_word = {busy_flag, 2'h0, scan[scan_sel]};
   wire in_wr = (sph == lcd_host_pkg::SP_WRDATA) && byte_done;
   wire in_rd = (sph == lcd_host_pkg::SP_RDDATA) && byte_done;
   wire status_done = in_rd && !reg_select;
   // queue entries; instructions dropped while busy
   logic fifo_in_ready;
   wire push_instr = in_wr && !reg_select && !busy_flag;
   wire push_valid = push_instr || ((in_wr || in_rd) && reg_select);
   lcd_host_pkg::op_t push_op;
   assign push_op.kind = !reg_select ? lcd_host_pkg::OP_INSTR :
                         in_rd ? lcd_host_pkg::OP_DATA_RD : lcd_host_pkg::OP_DATA_WR;
   assign push_op.data = rx_byte;
   // start byte decode, data shift, read shifting on falling edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sph <= lcd_host_pkg::SP_START;
         sclk_d <= 1'b0;
         bit_cnt <= 3'h0;
         rx <= 8'h00;
         tx <= 8'h00;
         reg_select <= 1'b0;
         serial_out <= 1'b0;
      end else begin
         sclk_d <= sclk_f;
         if (!selected) begin
            sph <= lcd_host_pkg::SP_START;
            bit_cnt <= 3'h0;
            serial_out <= 1'b0;
         end else begin
            if (sclk_rise) begin
               rx <= rx_byte;
               bit_cnt <= bit_cnt + 3'h1;
            end
            if (sclk_fall && sph == lcd_host_pkg::SP_RDDATA) begin
               serial_out <= tx[7];
               tx <= {tx[6:0], 1'b0};
            end
            if (byte_done) begin
               unique case (sph)
                  lcd_host_pkg::SP_START: begin
                     reg_select <= start_sel;
                     if (!start_ok) sph <= lcd_host_pkg::SP_DROP;
                     else if (start_rw) begin
                        sph <= lcd_host_pkg::SP_RDDATA;
                        tx <= start_sel ? data_transfer_register : status_word;
                     end else sph <= lcd_host_pkg::SP_WRDATA;
                  end
                  lcd_host_pkg::SP_WRDATA: sph <= lcd_host_pkg::SP_START;
                  lcd_host_pkg::SP_RDDATA: sph <= lcd_host_pkg::SP_START;
                  lcd_host_pkg::SP_DROP: sph <= lcd_host_pkg::SP_DROP;
               endcase
            end
         end
      end
   end

   // ****************************************
   // command queue
   // ****************************************
   logic fifo_out_valid;
   lcd_host_pkg::op_t pop_op;
   lcd_host_pkg::exec_state_t ex_state;
   wire take_op = (ex_state == lcd_host_pkg::EX_IDLE);
   // a full queue refuses data bytes; the host sees busy meanwhile
   op_fifo #(.WIDTH($bits(lcd_host_pkg::op_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(push_valid),
      .in_ready(fifo_in_ready),
      .in_data(push_op),
      .out_valid(fifo_out_valid),
      .out_ready(take_op),
      .out_data(pop_op)
   );

   // ****************************************
   // memories and address counter
   // ****************************************
   logic [7:0] display_ram [0:`DISP_DEPTH-1];
   logic [7:0] cgram [0:`CGRAM_DEPTH-1];
   logic [7:0] segram [0:`SEGRAM_DEPTH-1];
   logic [6:0] address_counter;
   lcd_host_pkg::ram_sel_t ram_sel;
   logic inc_mode;
   logic two_line;
   logic [5:0] clr_idx;
   logic [7:0] ex_cnt;
   // second line starts at its own base, packed after the first line
   function automatic logic [5:0] dd_index(input logic [6:0] a, input logic tl);
      dd_index = (tl && a[5]) ? (a[5:0] - 6'h20 + `LINE_LEN) : a[5:0];
   endfunction
   // one step of the counter with the wrap points of each memory
   function automatic logic [6:0] addr_step(input logic [6:0] a, input lcd_host_pkg::ram_sel_t s,
                                          input logic up, input logic tl);
      logic [6:0] r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (s == lcd_host_pkg::SEL_CG) r = {1'b0, r[5:0]};
      else if (s == lcd_host_pkg::SEL_SEG) r = {3'h0, r[3:0]};
      else if (!tl) begin
         if (up && a == `ONE_LINE_LAST) r = 7'h00;
         if (!up && a == 7'h00) r = `ONE_LINE_LAST;
      end else begin
         if (up && a == `LINE1_LAST) r = `LINE2_FIRST;
         if (up && a == `LINE2_LAST) r = 7'h00;
         if (!up && a == `LINE2_FIRST) r = `LINE1_LAST;
         if (!up && a == 7'h00) r = `LINE2_LAST;
      end
      addr_step = r;
   endfunction
   wire [5:0] dd_at = dd_index(address_counter, two_line);
   wire [7:0] mem_rd = (ram_sel == lcd_host_pkg::SEL_CG) ? cgram[address_counter[5:0]] :
                       (ram_sel == lcd_host_pkg::SEL_SEG) ? segram[address_counter[3:0]] :
                       display_ram[dd_at];
   wire pop = take_op && fifo_out_valid;
   wire [7:0] opd = pop_op.data;
   wire is_clear = pop && pop_op.kind == lcd_host_pkg::OP_INSTR && opd == `INS_CLEAR;
   wire is_entry = (opd & `INS_ENTRY_MASK) == `INS_ENTRY;
   wire is_disp = (opd & `INS_DISP_MASK) == `INS_DISP;
   wire is_seg = (opd & `INS_SEG_MASK) == `INS_SEG;
   wire is_cg = (opd & `INS_CG_MASK) == `INS_CG;
   wire is_dd = (opd & `INS_DD_MASK) == `INS_DD;
   wire is_wr = pop && pop_op.kind == lcd_host_pkg::OP_DATA_WR;
   wire is_rd = pop && pop_op.kind == lcd_host_pkg::OP_DATA_RD;
   wire is_ins = pop && pop_op.kind == lcd_host_pkg::OP_INSTR;
   wire clr_we = (ex_state == lcd_host_pkg::EX_CLEAR);
   wire dd_we = is_wr && ram_sel == lcd_host_pkg::SEL_DD;
   // memory writes: host data or the clear sweep
   always_ff @(posedge clk) begin
      if (clr_we) display_ram[clr_idx] <= `BLANK_CODE;
      else if (dd_we) display_ram[dd_at] <= opd;
      if (is_wr && ram_sel == lcd_host_pkg::SEL_CG) cgram[address_counter[5:0]] <= opd;
      if (is_wr && ram_sel == lcd_host_pkg::SEL_SEG) segram[address_counter[3:0]] <= opd;
   end

   // ****************************************
   // executor
   // ****************************************
   // busy covers queued work too, so an instruction never overtakes data
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ex_state <= lcd_host_pkg::EX_IDLE;
         ex_cnt <= 8'h00;
         clr_idx <= 6'h00;
         address_counter <= 7'h00;
         ram_sel <= lcd_host_pkg::SEL_DD;
         inc_mode <= 1'b1;
         display_on <= 1'b0;
         data_transfer_register <= 8'h00;
         busy_flag <= 1'b0;
      end else begin
         busy_flag <= fifo_out_valid || (ex_state != lcd_host_pkg::EX_IDLE);
         unique case (ex_state)
            lcd_host_pkg::EX_IDLE: begin
               if (pop) begin
                  ex_state <= lcd_host_pkg::EX_WAIT;
                  ex_cnt <= 8'(EXEC_CYCLES - 1);
               end
               if (is_clear) begin
                  ex_state <= lcd_host_pkg::EX_CLEAR;
                  clr_idx <= 6'h00;
                  address_counter <= 7'h00;
                  ram_sel <= lcd_host_pkg::SEL_DD;
               end else if (is_ins && is_dd) begin
                  address_counter <= opd[6:0];
                  ram_sel <= lcd_host_pkg::SEL_DD;
               end else if (is_ins && is_cg) begin
                  address_counter <= {1'b0, opd[5:0]};
                  ram_sel <= lcd_host_pkg::SEL_CG;
               end else if (is_ins && is_seg) begin
                  address_counter <= {3'h0, opd[3:0]};
                  ram_sel <= lcd_host_pkg::SEL_SEG;
               end else if (is_ins && is_disp) begin
                  display_on <= opd[`INS_DISP_ON_BIT];
               end else if (is_ins && is_entry) begin
                  inc_mode <= opd[`INS_INC_BIT];
               end
               if (is_wr || is_rd) begin
                  address_counter <= addr_step(address_counter, ram_sel, inc_mode, two_line);
               end
            end
            lcd_host_pkg::EX_CLEAR: begin
               if (clr_idx == 6'(`DISP_DEPTH - 1)) begin
                  ex_state <= lcd_host_pkg::EX_WAIT;
                  ex_cnt <= 8'(EXEC_CYCLES - 1);
               end
               clr_idx <= clr_idx + 6'h01;
            end
            lcd_host_pkg::EX_WAIT: begin
               // every operation ends by refreshing the data register
               if (ex_cnt == 8'h00) begin
                  ex_state <= lcd_host_pkg::EX_IDLE;
                  data_transfer_register <= mem_rd;
               end else ex_cnt <= ex_cnt - 8'h01;
            end
            default: ex_state <= lcd_host_pkg::EX_IDLE;
         endcase
      end
   end

   // ****************************************
   // line mode and key scan
   // ****************************************
   logic [23:0] strobe_cnt;
   logic [2:0] strobe_idx;
   wire strobe_end = (strobe_cnt == 24'(STROBE_CYCLES - 1));
   wire [2:0] strobe_next = (strobe_idx == 3'(`KEY_ROWS - 1)) ? 3'h0 : strobe_idx + 3'h1;
   wire key_event = strobe_end && (keys_pressed != '0) && (keys_pressed != scan[strobe_idx]);
   // one strobe low at a time; its rising edge captures the row
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strobe_cnt <= 24'h000000;
         strobe_idx <= 3'h0;
         key_strobe_n <= {`KEY_ROWS{1'b1}};
         for (int i = 0; i < `KEY_ROWS; i++) scan[i] <= '0;
         scan_sel <= 3'h0;
         irq_n <= 1'b1;
         two_line <= 1'b0;
         two_line_mode <= 1'b0;
         shared_drive_is_common <= 1'b0;
      end else begin
         two_line <= line_f;
         two_line_mode <= two_line;
         shared_drive_is_common <= two_line;
         strobe_cnt <= strobe_end ? 24'h000000 : strobe_cnt + 24'h000001;
         if (strobe_end) begin
            scan[strobe_idx] <= keys_pressed;
            strobe_idx <= strobe_next;
            key_strobe_n <= ~(`KEY_ROWS'(1) << strobe_next);
         end
         if (status_done) scan_sel <= (scan_sel == 3'(`KEY_ROWS - 1)) ? 3'h0 : scan_sel + 3'h1;
         // a new key event beats the clear from a status read
         if (key_event) irq_n <= 1'b0;
         else if (status_done) irq_n <= 1'b1;
      end
   end

   // ****************************************
   // extension driver stream
   // ****************************************
   logic [7:0] half_cnt;
   logic [8:0] dot_idx;
   wire half_end = (half_cnt == 8'(EXT_HALF - 1));
   wire [8:0] start_dot = two_line ? `EXT_START_DOT_2L : `EXT_START_DOT_1L;
   wire frame_end = (dot_idx == `EXT_LAST_DOT);
   wire [7:0] dot_byte = display_ram[dot_idx[8:3]];
   wire dot_bit = display_on && dot_byte[~dot_idx[2:0]];
   // data changes on the falling shift edge; latch and polarity turn per frame
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         half_cnt <= 8'h00;
         dot_idx <= `EXT_START_DOT_1L;
         ext_shift_clock <= 1'b0;
         ext_data <= 1'b0;
         ext_latch_pulse <= 1'b0;
         ext_polarity <= 1'b0;
      end else begin
         half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;
         if (half_end) begin
            ext_shift_clock <= !ext_shift_clock;
            ext_latch_pulse <= 1'b0;
            if (ext_shift_clock) begin
               ext_data <= dot_bit;
               if (frame_end) begin
                  dot_idx <= start_dot;
                  ext_latch_pulse <= 1'b1;
                  ext_polarity <= !ext_polarity;
               end else dot_idx <= dot_idx + 9'h001;
            end
         end
      end
   end
endmodule

/* File: core/lcd_host_map.svh */
// offsets, bit positions, codes and timing figures of the panel host port
// assumes inclusion by the design file, the property file and the bench, once each per unit
`ifndef LCD_HOST_MAP_SVH
`define LCD_HOST_MAP_SVH
// clock and times
`define CLK_PERIOD_NS 10
`define KEY_STROBE_US 1000
`define EXEC_TIME_NS 370
`define EXT_HALF_NS 500
// serial start byte and status word layout
`define START_SYNC 5'h1F
`define START_SYNC_HI 7
`define START_SYNC_LO 3
`define START_RW_BIT 2
`define START_SEL_BIT 1
`define STATUS_BUSY_BIT 7
// key matrix
`define KEY_COLS 5
`define KEY_ROWS 6
// memories and address map
`define DISP_DEPTH 40
`define CGRAM_DEPTH 64
`define SEGRAM_DEPTH 16
`define LINE_LEN 6'h14
`define LINE1_LAST 7'h13
`define LINE2_FIRST 7'h20
`define LINE2_LAST 7'h33
`define ONE_LINE_LAST 7'h27
`define BLANK_CODE 8'h20
// instruction codes
`define INS_CLEAR 8'h01
`define INS_ENTRY_MASK 8'hFC
`define INS_ENTRY 8'h04
`define INS_INC_BIT 1
`define INS_DISP_MASK 8'hF8
`define INS_DISP 8'h08
`define INS_DISP_ON_BIT 2
`define INS_SEG_MASK 8'hF0
`define INS_SEG 8'h10
`define INS_CG_MASK 8'hC0
`define INS_CG 8'h40
`define INS_DD_MASK 8'h80
`define INS_DD 8'h80
// extension driver dot stream and command queue depth
`define EXT_START_DOT_1L 9'h032
`define EXT_START_DOT_2L 9'h02A
`define EXT_LAST_DOT 9'h13F
`define OP_FIFO_DEPTH 16
`endif

/* File: core/lcd_host_pkg.sv */
// types shared by the panel host port and its command buffer
// assumes the map header sits in the same folder
package lcd_host_pkg;
   typedef enum logic [1:0] {OP_INSTR, OP_DATA_WR, OP_DATA_RD} op_kind_t;
   typedef enum logic [1:0] {SEL_DD, SEL_CG, SEL_SEG} ram_sel_t;
   typedef enum logic [1:0] {EX_IDLE, EX_WAIT, EX_CLEAR} exec_state_t;
   typedef enum logic [1:0] {SP_START, SP_WRDATA, SP_RDDATA, SP_DROP} serial_phase_t;
   typedef struct packed {
      op_kind_t kind;
      logic [7:0] data;
   } op_t;
endpackage

/* File: verif/lcd_host_port_properties.sv */
// concurrent checks on the pins of the panel host port
// assumes a bind onto the top module, pin names as there, one clock domain
`timescale 1ns/1ps
`include "lcd_host_map.svh"
module lcd_host_port_properties (
   input wire logic clk, // system clock
   input wire logic rstn, // async reset, low
   input wire logic cs_n, // select, low
   input wire logic sclk, // serial clock pin
   input wire logic serial_out, // read data pin
   input wire logic irq_n, // key interrupt, low
   input wire logic line_count_select, // mode pin
   input wire logic two_line_mode, // mode copy
   input wire logic shared_drive_is_common, // shared outputs as commons
   input wire logic ext_latch_pulse, // extension latch
   input wire logic ext_polarity, // extension polarity
   input wire logic [`KEY_ROWS-1:0] key_strobe_n // strobes, low
);
   // ****************************************
   // helper counters
   // ****************************************
   localparam int LATCH_CLKS = `EXT_HALF_NS / `CLK_PERIOD_NS;
   logic [`KEY_ROWS-1:0] prev_strobe;
   logic [3:0] since_rise;
   logic [7:0] latch_len;
   wire strobe_rise = |(key_strobe_n & ~prev_strobe);
   // both counters saturate so a long quiet spell never wraps into a false match
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev_strobe <= '1;
         since_rise <= 4'hF;
         latch_len <= 8'h00;
      end else begin
         prev_strobe <= key_strobe_n;
         since_rise <= strobe_rise ? 4'h0 : (since_rise == 4'hF ? 4'hF : since_rise + 4'h1);
         latch_len <= !ext_latch_pulse ? 8'h00 : (latch_len == 8'hFF ? 8'hFF : latch_len + 8'h01);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_DESEL_QUIET:
      assert property (cs_n [*8] |-> !serial_out)
         else $error("serial out active while deselected");
   AST_SOUT_AFTER_FALL:
      assert property (($changed(serial_out) && !cs_n) |-> !sclk)
         else $error("serial out moved with clock high");
   AST_MODE_COPY:
      assert property ($stable(line_count_select) [*8] |-> two_line_mode == line_count_select)
         else $error("line mode does not follow its pin");
   AST_SHARED_MATCH:
      assert property ($stable(two_line_mode) [*3] |-> shared_drive_is_common == two_line_mode)
         else $error("shared outputs disagree with mode");
   AST_ONE_STROBE:
      assert property ($countones(~key_strobe_n) <= 1) else $error("more than one strobe low");
   AST_STROBE_HOLD:
      assert property (($changed(key_strobe_n) && !(&key_strobe_n)) |=> $stable(key_strobe_n) [*8])
         else $error("strobe interval too short");
   AST_IRQ_ON_SCAN:
      assert property ($fell(irq_n) |-> (strobe_rise || since_rise <= 4'h5))
         else $error("interrupt without a strobe rise");
   AST_POL_AT_LATCH:
      assert property ($changed(ext_polarity) |-> (ext_latch_pulse || $past(ext_latch_pulse)
         || $past(ext_latch_pulse, 2))) else $error("polarity moved away from latch pulse");
   AST_LATCH_WIDTH:
      assert property ($fell(ext_latch_pulse) |-> latch_len == LATCH_CLKS)
         else $error("latch pulse width wrong");
endmodule

/* File: verif/lcd_host_model.sv */
// behavioural host controller on the four-wire serial link
// assumes the bench clock; link edges are spaced in whole clock cycles
`timescale 1ns/1ps
module lcd_host_model (
   input wire logic clk, // system clock
   input wire logic serial_out, // read data from device
   output logic cs_n, // select, low
   output logic sclk, // serial clock
   output logic serial_in // serial data
);
   // ****************************************
   // frame driver
   // ****************************************
   localparam int HALF = 8; // half period in clk cycles, room for the pin sync
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      serial_in = 1'b0;
   end
   // one start byte plus one data byte; sel low sends the same traffic unselected
   task automatic frame(input logic sel, input logic [1:0] rw_sel, input logic [7:0] wr,
                        output logic [7:0] rd);
      logic [15:0] bits;
      bits = {5'h1F, rw_sel, 1'b0, wr};
      rd = 8'h00;
      @(negedge clk);
      cs_n = !sel;
      for (int i = 15; i >= 0; i--) begin
         serial_in = bits[i];
         repeat (HALF) @(negedge clk);
         sclk = 1'b1;
         if (i < 8) rd[i] = serial_out;
         repeat (HALF) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (HALF) @(negedge clk);
      cs_n = 1'b1;
      serial_in = !serial_in; // a released line never keeps its last bit
   endtask
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the panel host port: serial access, memory, keys, extension
// assumes the design files and the map header are compiled first
`timescale 1ns/1ps
`include "lcd_host_map.svh"
module tb_top;
   // ****************************************
   // harness
   // ****************************************
   logic clk, rstn, line_count_select, p;
   logic [`KEY_COLS-1:0] key_input_n, pressed;
   logic [7:0] rd, x, y, mem [0:5];
   logic [6:0] tbl [0:2];
   wire cs_n, sclk, serial_in, serial_out, irq_n, two_line_mode, shared_drive_is_common;
   wire display_on, ext_latch_pulse, ext_shift_clock, ext_data, ext_polarity;
   wire [`KEY_ROWS-1:0] key_strobe_n;
   int failures, n_tests;
   lcd_panel_host_port_keyscan #(.STROBE_CYCLES(20)) DUT (.clk(clk), .rstn(rstn), .cs_n(cs_n),
      .sclk(sclk), .serial_in(serial_in), .serial_out(serial_out), .irq_n(irq_n),
      .line_count_select(line_count_select), .two_line_mode(two_line_mode),
      .shared_drive_is_common(shared_drive_is_common), .display_on(display_on),
      .ext_latch_pulse(ext_latch_pulse), .ext_shift_clock(ext_shift_clock), .ext_data(ext_data),
      .ext_polarity(ext_polarity), .key_strobe_n(key_strobe_n), .key_input_n(key_input_n));
   lcd_host_model host (.clk(clk), .serial_out(serial_out), .cs_n(cs_n), .sclk(sclk),
      .serial_in(serial_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // polls status until busy clears, bounded so a stuck flag ends the run
   task automatic wait_idle();
      for (int i = 0; i < 40; i++) begin
         host.frame(1'b1, 2'b10, 8'h00, rd);
         if (rd[7] === 1'b0) return;
      end
      failures++;
      complete_run();
   endtask
   task automatic ins(input logic [7:0] v);
      wait_idle();
      host.frame(1'b1, 2'b00, v, rd);
   endtask
   // next display address after an access, counting upward
   function automatic logic [6:0] step_addr(input logic [6:0] a, input logic two);
      if (!two) return (a == `ONE_LINE_LAST) ? 7'h00 : a + 7'h01;
      if (a == `LINE1_LAST) return `LINE2_FIRST;
      return (a == `LINE2_LAST) ? 7'h00 : a + 7'h01;
   endfunction
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      rstn = 1'b0;
      line_count_select = 1'b0;
      key_input_n = '1;
      failures = 0;
      n_tests = 0;
      tbl = '{7'h27, 7'h13, 7'h33};
      void'($urandom(32'h3A487082));
      repeat (8) @(negedge clk);
      check({7'h0, display_on}, 8'h00);
      check({2'h0, key_strobe_n}, 8'h3F);
      rstn = 1'b1;
      repeat (6) @(negedge clk);
      ins(8'h80);
      for (int i = 0; i < 6; i++) begin
         mem[i] = 8'($urandom);
         host.frame(1'b1, 2'b01, mem[i], rd);
      end
      host.frame(1'b0, 2'b01, ~mem[0], rd);
      ins(8'h80);
      for (int i = 0; i < 6; i++) begin
         host.frame(1'b1, 2'b11, 8'h00, rd);
         check(rd, mem[i]);
      end
      ins(8'h04);
      ins(8'h85);
      for (int i = 5; i > 2; i--) begin
         host.frame(1'b1, 2'b11, 8'h00, rd);
         check(rd, mem[i]);
      end
      ins(8'h06);
      ins(8'h01);
      ins(8'hA7);
      host.frame(1'b1, 2'b11, 8'h00, rd);
      check(rd, `BLANK_CODE);
      ins(8'h0C);
      check({7'h0, display_on}, 8'h01);
      for (int c = 0; c < 3; c++) begin
         line_count_select = (c != 0);
         repeat (8) @(negedge clk);
         check({7'h0, two_line_mode}, {7'h0, line_count_select});
         check({7'h0, shared_drive_is_common}, {7'h0, line_count_select});
         x = 8'($urandom);
         y = 8'($urandom);
         ins({1'b1, tbl[c]});
         host.frame(1'b1, 2'b01, x, rd);
         host.frame(1'b1, 2'b01, y, rd);
         ins({1'b1, step_addr(tbl[c], line_count_select)});
         host.frame(1'b1, 2'b11, 8'h00, rd);
         check(rd, y);
         ins({1'b1, tbl[c]});
         host.frame(1'b1, 2'b11, 8'h00, rd);
         check(rd, x);
      end
      pressed = 5'($urandom) | 5'h01;
      key_input_n = ~pressed;
      for (int i = 0; i < 300 && irq_n !== 1'b0; i++) @(negedge clk);
      check({7'h0, irq_n}, 8'h00);
      repeat (160) @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         host.frame(1'b1, 2'b10, 8'h00, rd);
         check({3'h0, rd[4:0]}, {3'h0, pressed});
      end
      check({7'h0, irq_n}, 8'h01);
      p = ext_polarity;
      for (int i = 0; i < 40000 && ext_latch_pulse !== 1'b1; i++) @(negedge clk);
      for (int i = 0; i < 200 && ext_latch_pulse !== 1'b0; i++) @(negedge clk);
      repeat (3) @(negedge clk);
      check({7'h0, ext_polarity}, {7'h0, !p});
      complete_run();
   end
endmodule
bind lcd_panel_host_port_keyscan lcd_host_port_properties chk (.clk(clk), .rstn(rstn),
   .cs_n(cs_n), .sclk(sclk), .serial_out(serial_out), .irq_n(irq_n),
   .line_count_select(line_count_select), .two_line_mode(two_line_mode),
   .shared_drive_is_common(shared_drive_is_common), .ext_latch_pulse(ext_latch_pulse),
   .ext_polarity(ext_polarity), .key_strobe_n(key_strobe_n));
